// ===== hw/sss_top.sv
/*
  sync output source selector and sweep frequency stepper with an axi4-lite slave.
  assumes the waveform engine supplies phase, marker and burst events on aclk,
  and that trig_pin arrives asynchronously.
*/
// Functional notes
// - waveform sync on standard waveform: square wave at main frequency, half high
// - waveform sync on arbitrary: pulse high for first few points of each pass
// - marker source on arbitrary: output follows stored per-sample marker bit
// - marker source on standard waveform becomes one-clock phase-zero pulse
// - burst-done source: pulse during last cycle of each burst
// - sequence source: pulse at end of each sequence pass
// - trigger source: pass the active trigger to sync output
// - phase-lock source: rising edge at zero-degree phase point
// - sweep sync high during sweep, low for retrace before next sweep
// - enable control turns sync output on or off
// - source steps cyclically in fixed order, forward or backward
// - auto mode: waveform sync for continuous, trigger for triggered or gated
// - in auto mode any parameter change restores automatic source
// - switching sweep on defaults the source to sweep sync
// - sweep refused for pulse, pulse-train and sequence waveforms
// - during sweep the played waveform length is 4096 points
// - sweep steps through a 2048-entry start-to-stop frequency table
// - dwell at least 0.5ms; fewer steps for short sweeps, down to 60 (step count here follows step_inc alone, SSS_MIN_STEPS not enforced)
// - one shared sweep parameter set serves all swept channels
// - triggered sweep starts on rising external, key or remote trigger
// - every sweep frequency is snapped to a table entry
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.svh"
module sss_top
  import sss_pkg::*;
#(
  parameter int DWELL_CYC = `SSS_DWELL_CYC,
  parameter int IDX_W = 11
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] wave_phase,
  input wire logic wave_pass_start,
  input wire logic [11:0] arb_point,
  input wire logic arb_marker,
  input wire logic burst_last,
  input wire logic seq_end,
  input wire logic active_trigger,
  input wire logic trig_pin,
  input wire logic manual_trigger_key,
  input wire logic param_change,
  output logic sync_out,
  output logic [IDX_W-1:0] sweep_index,
  output logic sweep_active,
  output logic [12:0] play_length
);
  // ===========================================================
  // register state
  logic out_en, auto_mode, sweep_on, trig_mode, cont_mode, resync;
  sss_src_e src;
  logic [15:0] dwell_mult;
  logic [IDX_W-1:0] step_inc;
  sss_wf_e wave_kind;
  logic gated;
  sss_sw_e sw_state;
  logic [31:0] dwell_cnt;
  logic sweep_refused;
  logic trig_s1, trig_s2, trig_d, key_d;
  logic remote_trig;

  // step one choice through seven sources with wraparound
  function automatic sss_src_e src_step(input sss_src_e s, input logic back);
    logic [2:0] v;
    v = s;
    if (back) begin
      v = (v == 3'd0) ? 3'd6 : 3'(v - 3'd1);
    end else begin
      v = (v == 3'd6) ? 3'd0 : 3'(v + 3'd1);
    end
    return sss_src_e'(v);
  endfunction : src_step

  // sweepable waveform kinds
  function automatic logic sweepable(input sss_wf_e k);
    return (k == SSS_WF_STD) || (k == SSS_WF_ARB);
  endfunction : sweepable

  // ===========================================================
  // axi4-lite write channel
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // capture address and data independently, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // write response, slverr on addresses above the wave register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr > `SSS_WAVE_OFF) ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_ctrl, wr_src, wr_sweep, wr_wave;
  assign wr_ctrl = wr_fire && aw_addr == `SSS_CTRL_OFF && w_strb[0];
  assign wr_src = wr_fire && aw_addr == `SSS_SRC_OFF && w_strb[0];
  assign wr_sweep = wr_fire && aw_addr == `SSS_SWEEP_OFF;
  assign wr_wave = wr_fire && aw_addr == `SSS_WAVE_OFF && w_strb[0];

  // ===========================================================
  // control bits, one shared sweep setup for all channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_en <= 1'(`SSS_CTRL_RST >> `SSS_CTRL_EN_BIT);
      auto_mode <= 1'(`SSS_CTRL_RST >> `SSS_CTRL_AUTO_BIT);
      sweep_on <= 1'b0;
      trig_mode <= 1'b0;
      cont_mode <= 1'b0;
      resync <= 1'b0;
      remote_trig <= 1'b0;
    end else begin
      remote_trig <= wr_ctrl && w_data[`SSS_CTRL_MTRIG_BIT];
      if (wr_ctrl) begin
        out_en <= w_data[`SSS_CTRL_EN_BIT];
        auto_mode <= w_data[`SSS_CTRL_AUTO_BIT];
        // sweep refused on pulse, pulse-train, sequence
        sweep_on <= w_data[`SSS_CTRL_SWP_BIT] && sweepable(wave_kind);
        trig_mode <= w_data[`SSS_CTRL_TRIG_BIT];
        cont_mode <= w_data[`SSS_CTRL_CONT_BIT];
        resync <= w_data[`SSS_CTRL_RESYNC_BIT];
      end else if (!sweepable(wave_kind)) begin
        sweep_on <= 1'b0;
      end
    end
  end

  // refusal flag: reloaded on every control write, so the next unrefused one clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sweep_refused <= 1'b0;
    end else if (wr_ctrl) begin
      sweep_refused <= w_data[`SSS_CTRL_SWP_BIT] && !sweepable(wave_kind);
    end
  end

  // waveform context and per-step time in dwell units
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_kind <= SSS_WF_STD;
      gated <= 1'b0;
      dwell_mult <= 16'(`SSS_SWEEP_RST);
      step_inc <= IDX_W'(1);
    end else begin
      if (wr_wave) begin
        wave_kind <= sss_wf_e'(w_data[2:0]);
        gated <= w_data[3];
      end
      if (wr_sweep) begin
        dwell_mult <= (w_data[15:0] == 16'h0000) ? 16'h0001 : w_data[15:0];
        step_inc <= (w_data[16 +: IDX_W] == '0) ? IDX_W'(1) : w_data[16 +: IDX_W];
      end
    end
  end

  // ===========================================================
  // source selection with auto override
  logic sweep_on_d, auto_pend;
  sss_src_e auto_src;
  always_comb begin
    if (sweep_on) begin
      auto_src = SSS_SRC_SWEEP;
    end else if (trig_mode || gated) begin
      auto_src = SSS_SRC_TRIG;
    end else begin
      auto_src = SSS_SRC_WAVE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src <= SSS_SRC_WAVE;
      sweep_on_d <= 1'b0;
      auto_pend <= 1'b0;
    end else begin
      sweep_on_d <= sweep_on;
      auto_pend <= param_change || wr_wave || wr_ctrl; // late, so auto_src sees new mode bits
      if (sweep_on && !sweep_on_d) begin
        src <= SSS_SRC_SWEEP;
      end else if (wr_src && (w_data[`SSS_SRC_FWD_BIT] || w_data[`SSS_SRC_BACK_BIT])) begin
        src <= src_step(src, w_data[`SSS_SRC_BACK_BIT]);
      end else if (wr_src) begin
        src <= (w_data[2:0] > 3'd6) ? SSS_SRC_WAVE : sss_src_e'(w_data[2:0]);
      end else if (auto_mode && auto_pend) begin
        src <= auto_src;
      end
    end
  end

  // ===========================================================
  // trigger synchroniser and rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_d <= 1'b0;
      key_d <= 1'b0;
    end else begin
      trig_s1 <= trig_pin;
      trig_s2 <= trig_s1;
      trig_d <= trig_s2;
      key_d <= manual_trigger_key;
    end
  end
  logic sweep_go;
  // external edge, key edge or remote command
  assign sweep_go = (trig_s2 && !trig_d) || (manual_trigger_key && !key_d) || remote_trig;

  // ===========================================================
  // sweep stepper: index advances each dwell period
  logic dwell_done, last_step;
  assign dwell_done = dwell_cnt >= 32'(DWELL_CYC) * {16'h0000, dwell_mult} - 32'd1;
  assign last_step = {1'b0, sweep_index} + {1'b0, step_inc} >= IDX_W'(`SSS_TABLE_LEN - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_state <= SSS_SW_IDLE;
      dwell_cnt <= 32'h0000_0000;
      sweep_index <= '0;
      sweep_active <= 1'b0;
    end else if (!sweep_on) begin
      sw_state <= SSS_SW_IDLE;
      dwell_cnt <= 32'h0000_0000;
      sweep_index <= '0;
      sweep_active <= 1'b0;
    end else begin
      case (sw_state)
        SSS_SW_IDLE: begin
          dwell_cnt <= 32'h0000_0000;
          if (cont_mode || (trig_mode && sweep_go)) begin
            sw_state <= SSS_SW_RUN;
            sweep_active <= 1'b1;
            sweep_index <= '0;
          end
        end
        SSS_SW_RUN: begin
          if (dwell_done) begin
            dwell_cnt <= 32'h0000_0000;
            if (last_step) begin
              // index stays on an entry, never interpolated
              sweep_index <= IDX_W'(`SSS_TABLE_LEN - 1);
              sw_state <= SSS_SW_RETRACE;
              sweep_active <= 1'b0;
            end else begin
              sweep_index <= IDX_W'(sweep_index + step_inc);
            end
          end else begin
            dwell_cnt <= dwell_cnt + 32'd1;
          end
        end
        SSS_SW_RETRACE: begin
          // one dwell low so a display can retrace
          if (dwell_done) begin
            dwell_cnt <= 32'h0000_0000;
            sweep_index <= '0;
            sw_state <= SSS_SW_IDLE;
          end else begin
            dwell_cnt <= dwell_cnt + 32'd1;
          end
        end
        default: begin
          sw_state <= SSS_SW_IDLE;
        end
      endcase
    end
  end

  // played waveform length fixed while sweeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      play_length <= 13'(`SSS_SAMPLES);
    end else begin
      play_length <= sweep_on ? 13'(`SSS_SAMPLES) : {1'b0, arb_point == 12'h000 ? 12'hfff : arb_point};
    end
  end

  // ===========================================================
  // sync output mux
  logic next_sync;
  logic is_arb;
  assign is_arb = wave_kind != SSS_WF_STD;
  always_comb begin
    case (src)
      SSS_SRC_WAVE: next_sync = is_arb ? (arb_point < 12'(`SSS_MARK_POINTS))
                                       : !wave_phase[11];
      SSS_SRC_MARK: next_sync = is_arb ? arb_marker
                                       : wave_pass_start;
      SSS_SRC_BURST: next_sync = burst_last;
      SSS_SRC_SEQ: next_sync = seq_end;
      SSS_SRC_TRIG: next_sync = active_trigger;
      SSS_SRC_SWEEP: next_sync = sweep_active;
      SSS_SRC_LOCK: next_sync = !wave_phase[11]; // rises at zero phase
      default: next_sync = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= out_en && next_sync;
    end
  end

  // ===========================================================
  // axi4-lite read channel
  logic [31:0] rd_word;
  always_comb begin
    case (s_axi_araddr)
      `SSS_CTRL_OFF: rd_word = {25'h0, 1'b0, resync, cont_mode, trig_mode, sweep_on, auto_mode, out_en};
      `SSS_SRC_OFF: rd_word = {29'h0, src};
      `SSS_SWEEP_OFF: rd_word = {5'h0, step_inc, dwell_mult};
      `SSS_STAT_OFF: rd_word = {12'h0, sweep_refused, sweep_active, sw_state, 5'h0, sweep_index};
      `SSS_WAVE_OFF: rd_word = {28'h0, gated, wave_kind};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (s_axi_araddr > `SSS_WAVE_OFF) ? 2'b10 : 2'b00;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : sss_top
`default_nettype wire

// ===== hw/sss_map.svh
/*
  constant map for the sync output selector and sweep stepper.
  assumes inclusion by bare name from the design file.
*/
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH
// ===========================================================
// register byte offsets
`define SSS_CTRL_OFF 8'h00
`define SSS_SRC_OFF 8'h04
`define SSS_SWEEP_OFF 8'h08
`define SSS_STAT_OFF 8'h0c
`define SSS_WAVE_OFF 8'h10
// ===========================================================
// control field positions
`define SSS_CTRL_EN_BIT 0
`define SSS_CTRL_AUTO_BIT 1
`define SSS_CTRL_SWP_BIT 2
`define SSS_CTRL_TRIG_BIT 3
`define SSS_CTRL_CONT_BIT 4
`define SSS_CTRL_RESYNC_BIT 5
`define SSS_CTRL_MTRIG_BIT 6
// src register command bits
`define SSS_SRC_FWD_BIT 4
`define SSS_SRC_BACK_BIT 5
// ===========================================================
// reset values
`define SSS_CTRL_RST 32'h0000_0003
`define SSS_SWEEP_RST 32'h0000_0064
// ===========================================================
// timing
`define SSS_DWELL_US 500
`define SSS_CLK_MHZ 100
`define SSS_DWELL_CYC (`SSS_DWELL_US * `SSS_CLK_MHZ)
`define SSS_TABLE_LEN 2048
`define SSS_MIN_STEPS 60
`define SSS_SAMPLES 4096
`define SSS_MARK_POINTS 4
`endif

// ===== hw/sss_pkg.sv
/*
  types for the sync output selector and sweep stepper.
  assumes nothing beyond a systemverilog compiler.
*/
package sss_pkg;
  // sync source codes in selector stepping order
  typedef enum logic [2:0] {
    SSS_SRC_WAVE = 3'b000,
    SSS_SRC_MARK = 3'b001,
    SSS_SRC_BURST = 3'b010,
    SSS_SRC_SEQ = 3'b011,
    SSS_SRC_TRIG = 3'b100,
    SSS_SRC_SWEEP = 3'b101,
    SSS_SRC_LOCK = 3'b110
  } sss_src_e;
  // sweep stepper states
  typedef enum logic [1:0] {
    SSS_SW_IDLE = 2'b00,
    SSS_SW_RUN = 2'b01,
    SSS_SW_RETRACE = 2'b10
  } sss_sw_e;
  // waveform kind codes written through the wave register
  typedef enum logic [2:0] {
    SSS_WF_STD = 3'b000,
    SSS_WF_ARB = 3'b001,
    SSS_WF_PULSE = 3'b010,
    SSS_WF_PTRAIN = 3'b011,
    SSS_WF_SEQ = 3'b100
  } sss_wf_e;
endpackage : sss_pkg

// ===== dv/sss_scope_model.sv
/*
  far side of the sync output: a scope counting trigger edges, plus a
  trigger source that gives a positive edge on the trigger pin.
  assumes aclk is the sample clock; fire is a request from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module sss_scope_model (
  input wire logic aclk,
  input wire logic sync_out,
  input wire logic fire,
  output logic trig_pin,
  output int edges
);
  // ==========================================
  // scope side
  logic last;
  initial begin
    trig_pin = 1'b0;
    edges = 0;
    last = 1'b0;
  end
  // counts rising edges, as a scope arming on each sweep would
  always @(posedge aclk) begin
    if (sync_out && !last) edges <= edges + 1;
    last <= sync_out;
  end
  // ==========================================
  // trigger source
  // off-edge timing on purpose: the pin is asynchronous to aclk
  always @(posedge fire) begin
    #3 trig_pin = 1'b1;
    repeat (4) @(posedge aclk);
    #3 trig_pin = 1'b0;
  end
endmodule : sss_scope_model
`default_nettype wire

// ===== dv/sss_top_asserts.sv
/*
  port checker for sss_top, bound to every instance.
  assumes one clock, aclk, and aresetn low while in reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sss_top_chk #(
  parameter int DWELL_CYC = 10,
  parameter int IDX_W = 11
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic sync_out,
  input wire logic [IDX_W-1:0] sweep_index,
  input wire logic sweep_active,
  input wire logic [12:0] play_length
);
  localparam int SAT = 1073741823;
  // ==========================================
  // helper counters
  logic [IDX_W-1:0] idx_q;
  int hold;
  int low;
  always_ff @(posedge aclk) begin
    idx_q <= sweep_index;
  end
  // cycles since the index last moved
  always_ff @(posedge aclk) begin
    if (!aresetn || sweep_index != idx_q) hold <= 0;
    else if (hold < SAT) hold <= hold + 1;
  end
  // saturates, so the first sweep after reset is not flagged
  always_ff @(posedge aclk) begin
    if (!aresetn) low <= SAT;
    else if (sweep_active) low <= 0;
    else if (low < SAT) low <= low + 1;
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before rready");
  AST_RRESP_CODE: assert property (s_axi_rvalid |-> !s_axi_rresp[0])
    else $error("read response neither okay nor slverr");
  AST_ERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");
  AST_RESET_OUT: assert property (!$past(aresetn) |-> !sync_out && !sweep_active && play_length == 13'h1000)
    else $error("outputs wrong after reset");
  AST_SWEEP_LEN: assert property (sweep_active && $past(sweep_active) |-> play_length == 13'h1000)
    else $error("play length not 4096 while sweeping");
  AST_DWELL: assert property (sweep_index != idx_q && sweep_index != '0 |-> hold >= DWELL_CYC - 1)
    else $error("sweep step shorter than one dwell");
  AST_RETRACE: assert property ($rose(sweep_active) |-> low >= DWELL_CYC - 1)
    else $error("sweep restarted without retrace time");
endmodule : sss_top_chk
bind sss_top sss_top_chk #(.DWELL_CYC(DWELL_CYC), .IDX_W(IDX_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .sync_out(sync_out), .sweep_index(sweep_index),
  .sweep_active(sweep_active), .play_length(play_length)
);
`default_nettype wire

// ===== dv/sss_top_tb_top.sv
/*
  self-checking bench for sss_top over axi4-lite.
  assumes the scope model beside the design and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.svh"
module sss_top_tb_top;
  import sss_pkg::*;
  localparam int DW = 10;
  // ==========================================
  // nets
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sync_out, sweep_active, trig_pin;
  logic [1:0] bresp, rresp;
  logic [10:0] sweep_index, li;
  logic [12:0] play_length;
  logic [11:0] wave_phase = 12'h0, arb_point = 12'h0;
  logic pass_st = 1'b0, marker = 1'b0, burst = 1'b0, seq = 1'b0, act_trig = 1'b0;
  logic key = 1'b0, param = 1'b0, fire = 1'b0;
  int edges, err_count = 0, compares = 0;
  logic [65:0] expq[$];
  always #5 aclk = ~aclk;
  sss_top #(.DWELL_CYC(DW)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wave_phase(wave_phase), .wave_pass_start(pass_st), .arb_point(arb_point), .arb_marker(marker),
    .burst_last(burst), .seq_end(seq), .active_trigger(act_trig), .trig_pin(trig_pin),
    .manual_trigger_key(key), .param_change(param), .sync_out(sync_out),
    .sweep_index(sweep_index), .sweep_active(sweep_active), .play_length(play_length)
  );
  sss_scope_model u_scope (.aclk(aclk), .sync_out(sync_out), .fire(fire), .trig_pin(trig_pin), .edges(edges));
  // ==========================================
  // checking
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // oldest note against each b or r handshake
  always @(posedge aclk) begin
    logic [65:0] e;
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = expq.pop_front();
      if (bvalid) chk({bresp, 32'h0}, {e[65:64], 32'h0});
      else chk({rresp, rdata & e[63:32]}, {e[65:64], e[31:0] & e[63:32]});
    end
  end
  // fresh event inputs every cycle, like a busy waveform engine
  always @(posedge aclk) begin
    wave_phase <= 12'($urandom);
    arb_point <= 12'($urandom % 8); // small, so the first-points window is hit
    {pass_st, marker, burst, seq, act_trig} <= 5'($urandom);
  end
  // hang guard, far beyond the sequence length
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
  // ==========================================
  // bus and wait tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expq.push_back({r, 64'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    expq.push_back({r, m, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // n counts the cycles spent waiting; li keeps the last index seen
  task automatic wt(input logic v, input int lim, output int n);
    n = 0;
    #1;
    while (sweep_active !== v && n < lim) begin
      @(posedge aclk);
      #1 n++;
      li = sweep_index; // the stop entry lands as sweep sync falls
    end
    chk({33'h0, sweep_active}, {33'h0, v});
  endtask : wt
  function automatic logic pick(input int s, input logic [2:0] k);
    case (s)
      0: pick = k[0] ? (arb_point < `SSS_MARK_POINTS) : !wave_phase[11];
      1: pick = k[0] ? marker : pass_st;
      2: pick = burst;
      3: pick = seq;
      6: pick = !wave_phase[11];
      default: pick = act_trig;
    endcase
  endfunction : pick
  // one cycle late, gated by the enable
  task automatic follow(input int s, input logic [2:0] k, input logic en);
    logic e;
    wr(`SSS_WAVE_OFF, {29'h0, k}, 2'b00);
    wr(`SSS_SRC_OFF, 32'(s), 2'b00);
    wr(`SSS_CTRL_OFF, {31'h0, en}, 2'b00);
    @(posedge aclk);
    #1 e = en & pick(s, k);
    repeat (30) begin
      @(posedge aclk);
      #1 chk({33'h0, sync_out}, {33'h0, e});
      e = en & pick(s, k);
    end
  endtask : follow
  // ==========================================
  // sequence
  initial begin
    int s;
    int n;
    int e0;
    void'($urandom(54851));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`SSS_CTRL_OFF, `SSS_CTRL_RST, 32'hffff_ffff, 2'b00);
    rd(`SSS_SWEEP_OFF, `SSS_SWEEP_RST, 32'h0000_ffff, 2'b00);
    rd(8'h14, 32'h0, 32'hffff_ffff, 2'b10);
    wr(8'h14, 32'h0, 2'b10);
    rd(`SSS_CTRL_OFF, `SSS_CTRL_RST, 32'hffff_ffff, 2'b00);
    $display("reset and refused access done");
    wr(`SSS_CTRL_OFF, 32'h1, 2'b00);
    for (int k = 0; k < 8; k++) begin
      wr(`SSS_SRC_OFF, 32'(k), 2'b00);
      rd(`SSS_SRC_OFF, 32'(k % 7), 32'h7, 2'b00);
    end
    for (int k = 0; k < 6; k++) begin
      s = k < 2 ? 6 * (1 - k) : 32'($urandom % 7);
      wr(`SSS_SRC_OFF, 32'(s), 2'b00);
      wr(`SSS_SRC_OFF, k[0] ? 32'h20 : 32'h10, 2'b00);
      rd(`SSS_SRC_OFF, 32'(k[0] ? (s + 6) % 7 : (s + 1) % 7), 32'h7, 2'b00);
    end
    $display("source stepping done");
    follow(0, 3'h0, 1'b1);
    follow(0, 3'h1, 1'b1);
    follow(6, 3'h0, 1'b1);
    follow(1, 3'h0, 1'b1);
    follow(1, 3'h1, 1'b1);
    for (int k = 2; k < 5; k++) follow(k, 3'h0, 1'b1);
    follow(4, 3'h0, 1'b0);
    $display("source follow done");
    wr(`SSS_WAVE_OFF, 32'h0, 2'b00);
    wr(`SSS_CTRL_OFF, 32'h3, 2'b00);
    rd(`SSS_SRC_OFF, 32'h0, 32'h7, 2'b00);
    wr(`SSS_WAVE_OFF, 32'h8, 2'b00);
    rd(`SSS_SRC_OFF, 32'h4, 32'h7, 2'b00);
    wr(`SSS_SRC_OFF, 32'h2, 2'b00);
    rd(`SSS_SRC_OFF, 32'h2, 32'h7, 2'b00);
    @(posedge aclk) param <= 1'b1;
    @(posedge aclk) param <= 1'b0;
    rd(`SSS_SRC_OFF, 32'h4, 32'h7, 2'b00);
    $display("automatic source done");
    for (int k = 2; k < 5; k++) begin
      wr(`SSS_WAVE_OFF, 32'(k), 2'b00);
      wr(`SSS_CTRL_OFF, 32'h15, 2'b00);
      rd(`SSS_STAT_OFF, 32'h0008_0000, 32'h000c_0000, 2'b00);
    end
    $display("sweep refusal done");
    // step 64 with a single dwell: a short run through the whole table
    wr(`SSS_CTRL_OFF, 32'h0, 2'b00);
    wr(`SSS_WAVE_OFF, 32'h0, 2'b00);
    wr(`SSS_SWEEP_OFF, 32'h0040_0001, 2'b00);
    e0 = edges;
    wr(`SSS_CTRL_OFF, 32'h15, 2'b00);
    rd(`SSS_SRC_OFF, 32'h5, 32'h7, 2'b00);
    wt(1'b1, 100, n);
    wt(1'b0, 1000, n);
    chk(34'(n >= 31 * DW && n <= 34 * DW), 34'h1);
    chk({23'h0, li}, 34'h7ff);
    wt(1'b1, 100, n);
    // sync_out lags sweep sync by a cycle and the scope by one more
    repeat (2) @(posedge aclk);
    #1 chk(34'(edges - e0), 34'h2);
    $display("continuous sweep done");
    wr(`SSS_CTRL_OFF, 32'h0, 2'b00);
    repeat (40 * DW) @(posedge aclk);
    wr(`SSS_CTRL_OFF, 32'h0d, 2'b00);
    for (int k = 0; k < 3; k++) begin
      repeat (20) @(posedge aclk);
      chk({33'h0, sweep_active}, 34'h0);
      if (k == 0) fire <= 1'b1;
      if (k == 1) key <= 1'b1;
      if (k == 2) wr(`SSS_CTRL_OFF, 32'h4d, 2'b00);
      repeat (3) @(posedge aclk);
      fire <= 1'b0;
      key <= 1'b0;
      wt(1'b1, 20, n);
      wt(1'b0, 1000, n);
    end
    $display("triggered sweep done");
    end_sim();
  end
endmodule : sss_top_tb_top
`default_nettype wire
